// ===== core/dcr_pkg.sv
package dcr_pkg;
    // Command bytes of the control group
    localparam logic [7:0] CMD_GRP_MASK = 8'h83;
    localparam logic [7:0] CMD_RESET = 8'hC3;
    localparam logic [7:0] CMD_LOAD = 8'hCF;
    localparam logic [7:0] CMD_CONTINUE = 8'hD3;
    localparam logic [7:0] CMD_DIS_INT = 8'hAF;
    localparam logic [7:0] CMD_EN_INT = 8'hAB;
    localparam logic [7:0] CMD_RST_DIS_INT = 8'hA3;
    localparam logic [7:0] CMD_EN_AFTER_RET = 8'hB7;
    localparam logic [7:0] CMD_RD_STATUS = 8'hBF;
    localparam logic [7:0] CMD_REINIT_STAT = 8'h8B;
    localparam logic [7:0] CMD_RD_MASK = 8'hBB;
    localparam logic [7:0] CMD_INIT_RD = 8'hA7;
    localparam logic [7:0] CMD_FORCE_RDY = 8'hB3;
    localparam logic [7:0] CMD_EN_DMA = 8'h87;
    localparam logic [7:0] CMD_DIS_DMA = 8'h83;
    // Two-byte return-from-interrupt opcode seen on instruction fetches
    localparam logic [7:0] RET_PREFIX = 8'hED;
    localparam logic [7:0] RET_OPCODE = 8'h4D;
    // Status byte fields
    localparam int ST_OPER = 0;
    localparam int ST_RDY = 1;
    localparam int ST_PEND_N = 3;
    localparam int ST_MATCH_N = 4;
    localparam int ST_EOB_N = 5;
    // Read sequence
    localparam int NUM_RD = 7;
    localparam logic [6:0] MASK_RESET = 7'h7F;
    // Controller register map, byte addresses
    localparam int ADDR_W = 5;
    localparam logic [4:0] OFF_CMD = 5'h00;
    localparam logic [4:0] OFF_READ = 5'h04;
    localparam logic [4:0] OFF_FETCH = 5'h08;
    localparam logic [4:0] OFF_ACK = 5'h0C;
    localparam logic [4:0] OFF_SVC = 5'h10;
    localparam logic [4:0] OFF_STAT = 5'h14;
    localparam logic [1:0] SVC_PLAIN = 2'h1;
    localparam logic [1:0] SVC_SNOOP = 2'h2;
    typedef enum {
        HS_IDLE,
        HS_SEND,
        HS_RDWAIT,
        HS_DONE
    } dcr_hstate_t;
endpackage : dcr_pkg

// ===== core/dcr_link_if.sv
`timescale 1ns/1ps
`default_nettype none
interface dcr_link_if;
    logic wr_stb;
    logic [7:0] wr_data;
    logic rd_stb;
    logic rd_ack;
    logic [7:0] rd_data;
    logic fetch_stb;
    logic [7:0] fetch_data;
    logic int_ack;
    logic irq;
    logic bus_req;
    modport dev (
        input wr_stb, wr_data, rd_stb, fetch_stb, fetch_data, int_ack,
        output rd_ack, rd_data, irq, bus_req
    );
    modport host (
        output wr_stb, wr_data, rd_stb, fetch_stb, fetch_data, int_ack,
        input rd_ack, rd_data, irq, bus_req
    );
endinterface : dcr_link_if
`default_nettype wire

// ===== core/dcr_device.sv
// Functional notes
// - Disable-interrupts drops request, keeps latches
// - Powers up disabled; enable command or config
// - Snooped return opcode re-arms interrupts
// - Conditions latch even while interrupts disabled
// - Host refuses enable command before reinit; plain service sends it anyway
// - Reset-disable clears pending, in-service, force, enable
// - Plain host ends service with three commands
// - Ready-interrupt latch blocks requests until re-arm
// - Snooping host writes re-arm then enable
// - Read-status returns status on next read
// - Reinit sets status bits four and five
// - Status byte layout: op, ready, pending
// - Host disables requests before status reinit
// - Load clears op bit unless a bus request is up in that cycle; load_o pulses a cycle late
// - Read-mask-follows stores next byte as mask
// - Reads walk masked registers in ascending order
// - Initiate-read points at lowest masked register
// - Read pointer survives other commands
// - Force-ready is ORed with external ready for bus requests only
// - Forced ready cancelled by listed events
// - Enable-requests command touches nothing else
// - Every other control byte disables requests
// - Group byte has bits seven, one, zero set
`timescale 1ns/1ps
`default_nettype none
module dcr_device (
    input wire logic clk_i,
    input wire logic rst_i,
    dcr_link_if.dev link,
    input wire logic ready_pin_i,
    input wire logic ready_high_i,
    input wire logic cfg_int_en_i,
    input wire logic cfg_dma_en_i,
    input wire logic int_on_match_i,
    input wire logic int_on_eob_i,
    input wire logic int_on_ready_i,
    input wire logic match_evt_i,
    input wire logic eob_evt_i,
    input wire logic bus_release_i,
    input wire logic [47:0] rr_bytes_i,
    output logic force_ready_o,
    output logic load_o
);
    import dcr_pkg::*;

    logic rdy_meta_reg;
    logic rdy_sync_reg;
    logic mask_next_reg;
    logic [6:0] mask_reg;
    logic [2:0] ptr_reg;
    logic stat_once_reg;
    logic ret_pre_reg;
    logic int_en_reg;
    logic pending_reg;
    logic in_service_reg;
    logic ready_irq_reg;
    logic dma_en_reg;
    logic force_reg;
    logic op_reg;
    logic match_n_reg;
    logic eob_n_reg;
    logic [7:0] rd_data_reg;
    logic rd_ack_reg;
    logic load_reg;
    logic is_cmd;
    logic ret_seen;
    logic rdy_active;
    logic ready_eff;
    logic ior_evt;
    logic cond_evt;
    logic [7:0] status;

    // Next masked register after position p, wrapping; p if mask empty
    function automatic logic [2:0] next_sel(input logic [6:0] m,
                                            input logic [2:0] p);
        logic [2:0] r;
        logic [2:0] idx;
        r = p;
        for (int i = NUM_RD; i >= 1; i--) begin
            idx = 3'((int'(p) + i) % NUM_RD);
            if (m[idx]) begin
                r = idx;
            end
        end
        return r;
    endfunction : next_sel

    function automatic logic cmd_is(input logic [7:0] c);
        return is_cmd && (link.wr_data == c);
    endfunction : cmd_is

    // A byte right after read-mask-follows is data, never a command
    assign is_cmd = link.wr_stb && !mask_next_reg
        && ((link.wr_data & CMD_GRP_MASK) == CMD_GRP_MASK);
    assign ret_seen = link.fetch_stb && ret_pre_reg
        && (link.fetch_data == RET_OPCODE);
    assign rdy_active = (rdy_sync_reg == ready_high_i);
    assign ready_eff = force_reg || rdy_active;
    assign ior_evt = int_on_ready_i && rdy_active && dma_en_reg
        && !ready_irq_reg && !in_service_reg;
    assign cond_evt = (match_evt_i && int_on_match_i)
        || (eob_evt_i && int_on_eob_i) || ior_evt;
    assign status = {2'b00, eob_n_reg, match_n_reg, !pending_reg, 1'b0,
                     rdy_active, op_reg};

    // Interrupt request is shut off while disabled or under service
    assign link.irq = pending_reg && int_en_reg && !in_service_reg;
    // Interrupt-on-ready must interrupt before the bus is requested
    assign link.bus_req = dma_en_reg && ready_eff && !ready_irq_reg
        && !in_service_reg && !ior_evt;
    assign link.rd_data = rd_data_reg;
    assign link.rd_ack = rd_ack_reg;
    assign force_ready_o = force_reg;
    assign load_o = load_reg;

    // Ready pin is asynchronous to clk_i
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            rdy_meta_reg <= 1'b0;
            rdy_sync_reg <= 1'b0;
        end else begin
            rdy_meta_reg <= ready_pin_i;
            rdy_sync_reg <= rdy_meta_reg;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ret_pre_reg <= 1'b0;
        end else if (link.fetch_stb) begin
            ret_pre_reg <= (link.fetch_data == RET_PREFIX);
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            int_en_reg <= 1'b0;
        end else if (cmd_is(CMD_DIS_INT) || cmd_is(CMD_RST_DIS_INT)
                     || cmd_is(CMD_RESET)) begin
            int_en_reg <= 1'b0;
        end else if (cmd_is(CMD_EN_INT) || cfg_int_en_i) begin
            int_en_reg <= 1'b1;
        end
    end

    // Set wins over every clear: a condition is never lost
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            pending_reg <= 1'b0;
        end else if (cond_evt) begin
            pending_reg <= 1'b1;
        end else if (cmd_is(CMD_RST_DIS_INT) || cmd_is(CMD_RESET)
                     || ret_seen) begin
            pending_reg <= 1'b0;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            in_service_reg <= 1'b0;
        end else if (link.int_ack && link.irq) begin
            in_service_reg <= 1'b1;
        end else if (cmd_is(CMD_RST_DIS_INT) || cmd_is(CMD_RESET)
                     || ret_seen) begin
            in_service_reg <= 1'b0;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ready_irq_reg <= 1'b0;
        end else if (ior_evt) begin
            ready_irq_reg <= 1'b1;
        end else if (cmd_is(CMD_EN_AFTER_RET) || cmd_is(CMD_RESET)) begin
            ready_irq_reg <= 1'b0;
        end
    end

    // Any written byte drops requesting except the enable command itself
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            dma_en_reg <= 1'b0;
        end else if (cmd_is(CMD_EN_DMA) || cfg_dma_en_i) begin
            dma_en_reg <= 1'b1;
        end else if (link.wr_stb) begin
            dma_en_reg <= 1'b0;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            force_reg <= 1'b0;
        end else if (cmd_is(CMD_RESET) || cmd_is(CMD_LOAD)
                     || cmd_is(CMD_RST_DIS_INT) || eob_evt_i
                     || match_evt_i || bus_release_i) begin
            force_reg <= 1'b0;
        end else if (cmd_is(CMD_FORCE_RDY)) begin
            force_reg <= 1'b1;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            op_reg <= 1'b0;
        end else if (link.bus_req) begin
            op_reg <= 1'b1;
        end else if (cmd_is(CMD_LOAD)) begin
            op_reg <= 1'b0;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            load_reg <= 1'b0;
        end else begin
            load_reg <= cmd_is(CMD_LOAD);
        end
    end

    // Found events win over a reinit in the same cycle
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            match_n_reg <= 1'b1;
        end else if (match_evt_i) begin
            match_n_reg <= 1'b0;
        end else if (cmd_is(CMD_REINIT_STAT) || cmd_is(CMD_RESET)) begin
            match_n_reg <= 1'b1;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            eob_n_reg <= 1'b1;
        end else if (eob_evt_i) begin
            eob_n_reg <= 1'b0;
        end else if (cmd_is(CMD_REINIT_STAT) || cmd_is(CMD_RESET)
                     || cmd_is(CMD_LOAD) || cmd_is(CMD_CONTINUE)) begin
            eob_n_reg <= 1'b1;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            mask_next_reg <= 1'b0;
            mask_reg <= MASK_RESET;
        end else if (mask_next_reg && link.wr_stb) begin
            mask_next_reg <= 1'b0;
            mask_reg <= link.wr_data[6:0];
        end else if (cmd_is(CMD_RD_MASK)) begin
            mask_next_reg <= 1'b1;
        end
    end

    // Reset command leaves the read sequence alone
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ptr_reg <= 3'h0;
            stat_once_reg <= 1'b0;
        end else if (cmd_is(CMD_INIT_RD)) begin
            ptr_reg <= next_sel(mask_reg, 3'(NUM_RD - 1));
            stat_once_reg <= 1'b0;
        end else if (cmd_is(CMD_RD_STATUS)) begin
            stat_once_reg <= 1'b1;
        end else if (link.rd_stb) begin
            if (stat_once_reg) begin
                stat_once_reg <= 1'b0;
            end else begin
                ptr_reg <= next_sel(mask_reg, ptr_reg);
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            rd_data_reg <= 8'h00;
            rd_ack_reg <= 1'b0;
        end else begin
            rd_ack_reg <= link.rd_stb;
            if (link.rd_stb) begin
                if (stat_once_reg || ptr_reg == 3'h0) begin
                    rd_data_reg <= status;
                end else begin
                    rd_data_reg <= rr_bytes_i[8 * (int'(ptr_reg) - 1) +: 8];
                end
            end
        end
    end
endmodule : dcr_device
`default_nettype wire

// ===== core/dcr_host.sv
`timescale 1ns/1ps
`default_nettype none
module dcr_host (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic [dcr_pkg::ADDR_W-1:0] avs_address_i,
    input wire logic avs_read_i,
    input wire logic avs_write_i,
    input wire logic [31:0] avs_writedata_i,
    output logic [31:0] avs_readdata_o,
    output logic avs_waitrequest_o,
    dcr_link_if.host link
);
    import dcr_pkg::*;

    dcr_hstate_t state_reg;
    logic [7:0] q_reg [0:2];
    logic [1:0] cnt_reg;
    logic wr_stb_reg;
    logic [7:0] wr_data_reg;
    logic rd_stb_reg;
    logic fetch_stb_reg;
    logic [7:0] fetch_data_reg;
    logic ack_reg;
    logic [31:0] rdata_reg;
    logic reinit_seen_reg;
    logic err_reg;
    logic take;
    logic [7:0] wbyte;

    assign take = (state_reg == HS_IDLE) && (avs_read_i || avs_write_i);
    assign wbyte = avs_writedata_i[7:0];
    assign avs_waitrequest_o = (state_reg != HS_DONE);
    assign avs_readdata_o = rdata_reg;
    assign link.wr_stb = wr_stb_reg;
    assign link.wr_data = wr_data_reg;
    assign link.rd_stb = rd_stb_reg;
    assign link.fetch_stb = fetch_stb_reg;
    assign link.fetch_data = fetch_data_reg;
    assign link.int_ack = ack_reg;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            state_reg <= HS_IDLE;
            cnt_reg <= 2'h0;
            err_reg <= 1'b0;
            for (int i = 0; i < 3; i++) begin
                q_reg[i] <= 8'h00;
            end
        end else begin
            case (state_reg)
                HS_IDLE: begin
                    if (take && avs_read_i) begin
                        state_reg <= (avs_address_i == OFF_READ)
                            ? HS_RDWAIT : HS_DONE;
                    end else if (take && avs_address_i == OFF_CMD) begin
                        state_reg <= HS_SEND;
                        if (wbyte == CMD_EN_INT && !reinit_seen_reg) begin
                            // Refused: nothing goes out on the link
                            err_reg <= 1'b1;
                            cnt_reg <= 2'h0;
                        end else if (wbyte == CMD_REINIT_STAT) begin
                            q_reg[0] <= CMD_DIS_DMA;
                            q_reg[1] <= wbyte;
                            cnt_reg <= 2'h2;
                        end else begin
                            q_reg[0] <= wbyte;
                            cnt_reg <= 2'h1;
                        end
                    end else if (take && avs_address_i == OFF_SVC) begin
                        state_reg <= HS_SEND;
                        if (avs_writedata_i[1:0] == SVC_PLAIN) begin
                            q_reg[0] <= CMD_RST_DIS_INT;
                            q_reg[1] <= CMD_EN_INT;
                            q_reg[2] <= CMD_EN_DMA;
                            cnt_reg <= 2'h3;
                        end else if (avs_writedata_i[1:0] == SVC_SNOOP) begin
                            q_reg[0] <= CMD_EN_AFTER_RET;
                            q_reg[1] <= CMD_EN_DMA;
                            cnt_reg <= 2'h2;
                        end else begin
                            cnt_reg <= 2'h0;
                        end
                    end else if (take) begin
                        state_reg <= HS_DONE;
                    end
                end
                HS_SEND: begin
                    if (cnt_reg == 2'h0) begin
                        state_reg <= HS_DONE;
                    end else begin
                        cnt_reg <= cnt_reg - 2'h1;
                        q_reg[0] <= q_reg[1];
                        q_reg[1] <= q_reg[2];
                    end
                end
                HS_RDWAIT: begin
                    if (link.rd_ack) begin
                        state_reg <= HS_DONE;
                    end
                end
                HS_DONE: begin
                    state_reg <= HS_IDLE;
                end
                default: begin
                    state_reg <= HS_IDLE;
                end
            endcase
        end
    end

    // Read, fetch and ack strobes are single-cycle pulses; write strobe stays high one cycle per queued byte
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wr_stb_reg <= 1'b0;
            wr_data_reg <= 8'h00;
            rd_stb_reg <= 1'b0;
            fetch_stb_reg <= 1'b0;
            fetch_data_reg <= 8'h00;
            ack_reg <= 1'b0;
        end else begin
            wr_stb_reg <= (state_reg == HS_SEND) && (cnt_reg != 2'h0);
            if (state_reg == HS_SEND) begin
                wr_data_reg <= q_reg[0];
            end
            rd_stb_reg <= take && avs_read_i && avs_address_i == OFF_READ;
            fetch_stb_reg <= take && avs_write_i
                && avs_address_i == OFF_FETCH;
            if (take && avs_write_i && avs_address_i == OFF_FETCH) begin
                fetch_data_reg <= wbyte;
            end
            ack_reg <= take && avs_write_i && avs_address_i == OFF_ACK;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            reinit_seen_reg <= 1'b0;
        end else if (wr_stb_reg && wr_data_reg == CMD_REINIT_STAT) begin
            reinit_seen_reg <= 1'b1;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            rdata_reg <= 32'h0000_0000;
        end else if (state_reg == HS_RDWAIT && link.rd_ack) begin
            rdata_reg <= {24'h00_0000, link.rd_data};
        end else if (take) begin
            rdata_reg <= (avs_read_i && avs_address_i == OFF_STAT)
                ? {28'h000_0000, err_reg, reinit_seen_reg, link.bus_req,
                   link.irq}
                : 32'h0000_0000;
        end
    end
endmodule : dcr_host
`default_nettype wire

// ===== sim/dcr_assertions.sv
`timescale 1ns/1ps
`default_nettype none
module dcr_assertions (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic wr_stb,
    input wire logic [7:0] wr_data,
    input wire logic rd_stb,
    input wire logic rd_ack,
    input wire logic [7:0] rd_data,
    input wire logic fetch_stb,
    input wire logic [7:0] fetch_data,
    input wire logic int_ack,
    input wire logic irq,
    input wire logic bus_req
);
    import dcr_pkg::*;
    logic ed_seen_reg;
    logic en_seen_reg;
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);
    // Return opcode only counts straight after the prefix fetch
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ed_seen_reg <= 1'b0;
        end else if (fetch_stb) begin
            ed_seen_reg <= fetch_data == RET_PREFIX;
        end
    end
    // Last written byte was the request enable
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            en_seen_reg <= 1'b0;
        end else if (wr_stb) begin
            en_seen_reg <= wr_data == CMD_EN_DMA;
        end
    end
    AST_RD_ACK: assert property (rd_stb |=> rd_ack ##1 !rd_ack)
        else $error("read answer not a single pulse");
    AST_ACK_CAUSE: assert property (rd_ack |-> $past(rd_stb))
        else $error("read answer without request");
    AST_RD_HOLD: assert property ($changed(rd_data) |-> rd_ack)
        else $error("read data moved between reads");
    AST_DIS_INT: assert property (
        wr_stb && wr_data == CMD_DIS_INT |=> !irq)
        else $error("irq still high after disable");
    AST_RST_DIS: assert property (
        wr_stb && wr_data == CMD_RST_DIS_INT |=> !irq)
        else $error("irq still high after reset-disable");
    AST_DISABLE: assert property (
        wr_stb && wr_data != CMD_EN_DMA |=> !bus_req)
        else $error("bus request survived a control byte");
    AST_ENABLE_ONLY: assert property ($rose(bus_req) |-> en_seen_reg)
        else $error("bus request without enable");
    AST_RETURN: assert property (
        fetch_stb && fetch_data == RET_OPCODE && ed_seen_reg |=> !irq)
        else $error("irq kept after return");
    AST_SERVICE: assert property (int_ack && irq |=> !bus_req)
        else $error("bus request while in service");
endmodule : dcr_assertions
`default_nettype wire

// ===== sim/dma_command_register_logic_test.sv
`timescale 1ns/1ps
`default_nettype none
module dma_command_register_logic_test;
    import dcr_pkg::*;
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic [4:0] avs_address_i = 5'h00;
    logic avs_read_i = 1'b0;
    logic avs_write_i = 1'b0;
    logic [31:0] avs_writedata_i = 32'h0;
    logic [31:0] avs_readdata_o;
    logic avs_waitrequest_o;
    logic ready_pin_i = 1'b0;
    logic ready_high_i = 1'b1;
    logic int_on_eob_i = 1'b0;
    logic int_on_ready_i = 1'b0;
    logic [3:0] ev = 4'h0;
    logic [47:0] rr_bytes_i = 48'h0;
    logic force_ready_o;
    logic load_o;
    logic [31:0] q;
    logic [7:0] b;
    logic [6:0] m;
    logic [7:0] grp [12];
    int fail_count = 0;
    int compares = 0;
    int k;
    int loads = 0;
    dcr_link_if link();
    dcr_host u_dcr_host (.clk_i(clk_i), .rst_i(rst_i),
        .avs_address_i(avs_address_i), .avs_read_i(avs_read_i),
        .avs_write_i(avs_write_i), .avs_writedata_i(avs_writedata_i),
        .avs_readdata_o(avs_readdata_o),
        .avs_waitrequest_o(avs_waitrequest_o), .link(link));
    // Events: 0 config enable, 1 end of block, 2 match, 3 bus release
    dcr_device u_dcr_device (.clk_i(clk_i), .rst_i(rst_i), .link(link),
        .ready_pin_i(ready_pin_i), .ready_high_i(ready_high_i),
        .cfg_int_en_i(ev[0]), .cfg_dma_en_i(1'b0),
        .int_on_match_i(int_on_eob_i), .int_on_eob_i(int_on_eob_i),
        .int_on_ready_i(int_on_ready_i), .match_evt_i(ev[2]),
        .eob_evt_i(ev[1]), .bus_release_i(ev[3]),
        .rr_bytes_i(rr_bytes_i), .force_ready_o(force_ready_o),
        .load_o(load_o));
    dcr_assertions u_dcr_assertions (.clk_i(clk_i), .rst_i(rst_i),
        .wr_stb(link.wr_stb), .wr_data(link.wr_data),
        .rd_stb(link.rd_stb), .rd_ack(link.rd_ack),
        .rd_data(link.rd_data), .fetch_stb(link.fetch_stb),
        .fetch_data(link.fetch_data), .int_ack(link.int_ack),
        .irq(link.irq), .bus_req(link.bus_req));
    always #4 clk_i = ~clk_i;
    // Counts load pulses, so a stuck or doubled pulse shows up
    always @(posedge clk_i) begin
        if (load_o === 1'b1) loads <= loads + 1;
    end
    task automatic wrap_up();
        $display("compares=%0d fail_count=%0d", compares, fail_count);
        if (fail_count == 0 && compares > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : wrap_up
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            fail_count++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    task automatic cyc(input int n);
        repeat (n) @(posedge clk_i);
    endtask : cyc
    // Called just after an edge; returns one edge after the answer
    task automatic av(input logic wr, input logic [4:0] a,
                      input logic [7:0] d);
        int n;
        n = 0;
        avs_address_i <= a;
        avs_write_i <= wr;
        avs_read_i <= !wr;
        avs_writedata_i <= {24'h000000, d};
        do begin
            @(posedge clk_i);
            n++;
        end while (avs_waitrequest_o !== 1'b0 && n < 100);
        q = avs_readdata_o;
        avs_write_i <= 1'b0;
        avs_read_i <= 1'b0;
        if (avs_waitrequest_o !== 1'b0) begin
            fail_count++;
            wrap_up();
        end
        @(posedge clk_i);
    endtask : av
    task automatic cmd(input logic [7:0] c);
        av(1'b1, OFF_CMD, c);
    endtask : cmd
    task automatic rd_status();
        cmd(CMD_RD_STATUS);
        av(1'b0, OFF_READ, 8'h00);
    endtask : rd_status
    task automatic pulse(input int n);
        ev <= 4'(1 << n);
        @(posedge clk_i);
        ev <= 4'h0;
        cyc(2);
    endtask : pulse
    task automatic ret();
        av(1'b1, OFF_ACK, 8'h00);
        av(1'b1, OFF_FETCH, RET_PREFIX);
        av(1'b1, OFF_FETCH, RET_OPCODE);
    endtask : ret
    task automatic done(input string s);
        $display("test %s finished", s);
    endtask : done
    function automatic int nth(input logic [6:0] mk, input int i);
        int c;
        c = 0;
        for (int j = 0; j < 70; j++) begin
            if (mk[j % 7]) begin
                if (c == i) return j % 7;
                c++;
            end
        end
        return 0;
    endfunction : nth
    function automatic logic [7:0] rr_exp(input int n);
        return (n == 0) ? 8'h38 : rr_bytes_i[8 * n - 1 -: 8];
    endfunction : rr_exp
    initial begin
        grp = '{CMD_DIS_DMA, CMD_DIS_INT, CMD_RST_DIS_INT, CMD_EN_AFTER_RET,
            CMD_RD_STATUS, CMD_REINIT_STAT, CMD_INIT_RD, CMD_FORCE_RDY,
            CMD_LOAD, CMD_CONTINUE, CMD_EN_INT, CMD_RESET};
        void'($urandom(18));
        rr_bytes_i <= 48'({$urandom(), $urandom()});
        repeat (20) @(posedge clk_i);
        rst_i <= 1'b0;
        @(posedge clk_i);
        for (int t = 0; t < 4; t++) begin
            m = (t == 0) ? 7'h19 : 7'($urandom_range(1, 127));
            cmd(CMD_RD_MASK);
            cmd({1'b0, m});
            cmd(CMD_INIT_RD);
            for (int i = 0; i < 2 * $countones(m); i++) begin
                k = nth(m, i);
                av(1'b0, OFF_READ, 8'h00);
                chk(q[7:0] & ((k == 0) ? 8'h3B : 8'hFF), rr_exp(k));
                if (i == 0) cmd(CMD_DIS_DMA);
            end
        end
        rd_status();
        chk(q[7:0] & 8'h3B, 8'h38);
        done("read sequence");
        // Enable before status reinit must be turned away by the host
        cmd(CMD_EN_INT);
        av(1'b0, OFF_STAT, 8'h00);
        chk(q[3:2], 2'b10);
        cmd(CMD_REINIT_STAT);
        av(1'b0, OFF_STAT, 8'h00);
        chk(q[2], 1'b1);
        done("refusal");
        int_on_eob_i <= 1'b1;
        pulse(1);
        chk(link.irq, 1'b0);
        rd_status();
        chk(q[5], 1'b0);
        cmd(CMD_EN_INT);
        chk(link.irq, 1'b1);
        cmd(CMD_DIS_INT);
        chk(link.irq, 1'b0);
        pulse(0);
        chk(link.irq, 1'b1);
        av(1'b1, OFF_ACK, 8'h00);
        cmd(CMD_RST_DIS_INT);
        cmd(CMD_EN_INT);
        chk(link.irq, 1'b0);
        rd_status();
        chk(q[3], 1'b1);
        cmd(CMD_REINIT_STAT);
        rd_status();
        chk(q[5:4], 2'b11);
        pulse(1);
        chk(link.irq, 1'b1);
        ret();
        chk(link.irq, 1'b0);
        pulse(2);
        chk(link.irq, 1'b1);
        av(1'b1, OFF_SVC, SVC_PLAIN);
        chk(link.irq, 1'b0);
        done("interrupts");
        int_on_eob_i <= 1'b0;
        ready_pin_i <= 1'b1;
        cyc(3);
        cmd(CMD_EN_DMA);
        chk(link.bus_req, 1'b1);
        for (int i = 0; i < 18; i++) begin
            b = (i < 12) ? grp[i] : 8'($urandom());
            if (i >= 12 && (b & 8'h83) == 8'h83) b[0] = 1'b0;
            cmd(b);
            chk(link.bus_req, 1'b0);
            cmd(CMD_EN_DMA);
            chk(link.bus_req, 1'b1);
        end
        ready_high_i <= 1'b0;
        cyc(3);
        cmd(CMD_EN_DMA);
        chk(link.bus_req, 1'b0);
        ready_pin_i <= 1'b0;
        cyc(3);
        chk(link.bus_req, 1'b1);
        rd_status();
        chk(q[1:0], 2'b11);
        cmd(CMD_LOAD);
        chk(loads, 2);
        rd_status();
        chk(q[0], 1'b0);
        done("bus request");
        ready_high_i <= 1'b1;
        for (int i = 0; i < 6; i++) begin
            cmd(CMD_FORCE_RDY);
            cmd(CMD_EN_DMA);
            chk({force_ready_o, link.bus_req}, 2'b11);
            b = (i == 0) ? CMD_RST_DIS_INT : (i == 1) ? CMD_LOAD : CMD_RESET;
            if (i < 3) cmd(b);
            else pulse(i - 2);
            chk(force_ready_o, 1'b0);
        end
        rd_status();
        chk(q[5:4], 2'b00);
        done("force ready");
        int_on_ready_i <= 1'b1;
        cmd(CMD_EN_INT);
        cmd(CMD_EN_DMA);
        ready_pin_i <= 1'b1;
        // Two sync stages, one cycle for the latch, one to be seen settled
        cyc(4);
        chk({link.irq, link.bus_req}, 2'b10);
        ret();
        cmd(CMD_EN_DMA);
        chk(link.bus_req, 1'b0);
        int_on_ready_i <= 1'b0;
        av(1'b1, OFF_SVC, SVC_SNOOP);
        chk(link.bus_req, 1'b1);
        done("ready interrupt");
        wrap_up();
    end
endmodule : dma_command_register_logic_test
`default_nettype wire
